// *** rtl/bcs_bridge_regs.sv ***
// Behaviour
// - Command bits 9,7,6,4,3 read zero and ignore writes.
// - With message enable clear, no system-error message ever leaves.
// - With message enable set, any enabled error condition sends a message.
// - No system-error pin; errors are reported only as hub messages.
// - The message enable governs only this bridge function's messages.
// - Bus master bit is plain storage with no effect.
// - Memory enable clear means no memory window decodes.
// - Memory enable set forwards hits in memory and prefetchable windows.
// - I/O enable clear means no I/O space decodes.
// - The I/O window decodes only while I/O enable reads one.
// - Signaled system error sets whenever a message is sent.
// - That flag stays until software writes one; zero leaves it.
// - Status parity and abort flags read zero and ignore writes.
// - Select timing field reads 00b and ignores writes.
// - Status bit 7 reads one, fast back-to-back capable.
// - Status bit 5 reads one, fast clock capable.
// - Status reports best capabilities so it never limits the bus.
`include "bcs_map.svh"
`default_nettype none

module bcs_bridge_regs #(
    parameter int NUM_ERR = 4
) (
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire bcs_pkg::bcs_cfg_req_t I_CFG,
    output var bcs_pkg::bcs_cfg_rsp_t O_CFG,
    input wire logic [NUM_ERR-1:0] I_ERR_EVENT,
    input wire logic [NUM_ERR-1:0] I_ERR_ENABLE,
    output logic O_SYSERR_MSG_VALID,
    input wire logic I_SYSERR_MSG_READY,
    input wire bcs_pkg::bcs_win_t I_MEM_WIN,
    input wire bcs_pkg::bcs_win_t I_PMEM_WIN,
    input wire logic [7:0] I_IO_BASE,
    input wire logic [7:0] I_IO_LIMIT,
    input wire logic [31:0] I_MEM_ADDR,
    input wire logic [15:0] I_IO_ADDR,
    output logic O_MEM_HIT,
    output logic O_IO_HIT,
    output logic O_MEM_ENABLE,
    output logic O_IO_ENABLE
);
    import bcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Access decode.

    // True when an access targets the dword holding both registers.
    function automatic logic hits_regs(input logic [7:0] addr);
        hits_regs = ((addr & `BCS_DWORD_MASK) == `BCS_CMD_OFFSET);
    endfunction

    logic wr_regs;
    logic rd_regs;
    logic [15:0] cmd_q;
    logic sse_q;
    logic [15:0] status;
    logic [15:0] cmd_lane_mask;
    logic [15:0] cmd_wdata;
    logic sse_clear;
    logic msg_sent;
    logic err_pending;
    bcs_msg_state_t msg_state_q;
    bcs_cfg_rsp_t rsp_q;
    logic mem_hit_q;
    logic io_hit_q;
    logic [1:0] mwin_hit;
    logic io_hit;

    // Both registers answer to one dword; anything else reads as zero.
    assign wr_regs = I_CFG.wr && hits_regs(I_CFG.addr);
    assign rd_regs = I_CFG.rd && hits_regs(I_CFG.addr);

    ////////////////////////////////////////////////////////////////////////////
    // Command register.

    // Byte enables select which command lanes a write may touch.
    assign cmd_lane_mask = {{8{I_CFG.be[1]}}, {8{I_CFG.be[0]}}};
    assign cmd_wdata = I_CFG.wdata[15:0];

    // Only the four storage bits are held; hardwired zeros are masked out.
    // hardwired zero bits
    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            cmd_q <= `BCS_CMD_RESET;
        end
        else if (wr_regs)
        begin
            cmd_q <= ((cmd_q & ~cmd_lane_mask) | (cmd_wdata & cmd_lane_mask))
                     & `BCS_CMD_WMASK;
        end
    end

    // The bus master bit is not consumed anywhere, by intent.
    assign O_MEM_ENABLE = cmd_q[`BCS_CMD_MAE];
    assign O_IO_ENABLE = cmd_q[`BCS_CMD_IOAE];

    ////////////////////////////////////////////////////////////////////////////
    // Status register.

    // Software clears the sticky flag by writing one to its lane.
    assign sse_clear = wr_regs && I_CFG.be[`BCS_STS_SSE_BYTE]
                       && I_CFG.wdata[`BCS_STS_WORD_LSB + `BCS_STS_SSE];

    // A message sent in the clearing cycle wins, so no error is lost.
    // flag on message
    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            sse_q <= 1'b0;
        end
        else if (msg_sent)
        begin
            sse_q <= 1'b1;
        end
        else if (sse_clear)
        begin
            sse_q <= 1'b0;
        end
    end

    // Everything but the flag is constant: best-case capabilities for the bus.
    // abort bits zero
    assign status = `BCS_STS_FIXED | (16'(sse_q) << `BCS_STS_SSE);

    ////////////////////////////////////////////////////////////////////////////
    // Read path.

    // Data is registered so the answer never glitches on the bus.
    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            rsp_q <= '0;
        end
        else
        begin
            rsp_q.rvalid <= I_CFG.rd;
            rsp_q.rdata <= rd_regs ? {status, cmd_q} : 32'h0000_0000;
        end
    end
    assign O_CFG = rsp_q;

    ////////////////////////////////////////////////////////////////////////////
    // System-error messaging toward the hub.

    // An error counts only when its own bridge-control enable is set.
    assign err_pending = |(I_ERR_EVENT & I_ERR_ENABLE);

    // A message is sent again while the error lasts; the sender waits for the hub to take it.
    // send on enabled error
    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            msg_state_q <= BCS_MSG_IDLE;
        end
        else
        begin
            unique case (msg_state_q)
                BCS_MSG_IDLE:
                begin
                    if (err_pending && cmd_q[`BCS_CMD_SERRE])
                    begin
                        msg_state_q <= BCS_MSG_SEND;
                    end
                end
                BCS_MSG_SEND:
                begin
                    // Dropping the enable abandons the message not yet taken.
                    if (I_SYSERR_MSG_READY || !cmd_q[`BCS_CMD_SERRE])
                    begin
                        msg_state_q <= BCS_MSG_IDLE;
                    end
                end
                default:
                begin
                    msg_state_q <= BCS_MSG_IDLE;
                end
            endcase
        end
    end

    // The valid is gated live by the enable, so no message escapes after it drops.
    // gated by enable
    assign O_SYSERR_MSG_VALID = (msg_state_q == BCS_MSG_SEND) && cmd_q[`BCS_CMD_SERRE];
    assign msg_sent = O_SYSERR_MSG_VALID && I_SYSERR_MSG_READY;

    ////////////////////////////////////////////////////////////////////////////
    // Window decode.

    // Memory and prefetchable windows share one compare shape.
    // memory off
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_mwin
            bcs_win_t win;
            assign win = (gi == 0) ? I_MEM_WIN : I_PMEM_WIN;
            bcs_range_check #(
                .W(`BCS_MADDR_MSB - `BCS_MADDR_LSB + 1)
            ) bcs_range_check_i (
                .i_enable(cmd_q[`BCS_CMD_MAE]),
                .i_addr(I_MEM_ADDR[`BCS_MADDR_MSB:`BCS_MADDR_LSB]),
                .i_base(win.base[`BCS_MWIN_MSB:`BCS_MWIN_LSB]),
                .i_limit(win.limit[`BCS_MWIN_MSB:`BCS_MWIN_LSB]),
                .o_hit(mwin_hit[gi])
            );
        end
    endgenerate

    // I/O range is 4 KB granular on address bits 15:12.
    // I/O off
    bcs_range_check #(
        .W(`BCS_IOADDR_MSB - `BCS_IOADDR_LSB + 1)
    ) bcs_range_check_i (
        .i_enable(cmd_q[`BCS_CMD_IOAE]),
        .i_addr(I_IO_ADDR[`BCS_IOADDR_MSB:`BCS_IOADDR_LSB]),
        .i_base(I_IO_BASE[`BCS_IOWIN_MSB:`BCS_IOWIN_LSB]),
        .i_limit(I_IO_LIMIT[`BCS_IOWIN_MSB:`BCS_IOWIN_LSB]),
        .o_hit(io_hit)
    );

    // Hits are registered; a decode answers one cycle after its address.
    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            mem_hit_q <= 1'b0;
            io_hit_q <= 1'b0;
        end
        else
        begin
            mem_hit_q <= |mwin_hit;
            io_hit_q <= io_hit;
        end
    end
    assign O_MEM_HIT = mem_hit_q;
    assign O_IO_HIT = io_hit_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_RST);

    // Reference decode for the checks, written apart from the range checker.
    logic [`BCS_MADDR_MSB-`BCS_MADDR_LSB:0] chk_maddr;
    logic [`BCS_MADDR_MSB-`BCS_MADDR_LSB:0] chk_mbase;
    logic [`BCS_MADDR_MSB-`BCS_MADDR_LSB:0] chk_mlimit;
    logic [`BCS_IOADDR_MSB-`BCS_IOADDR_LSB:0] chk_ioaddr;
    logic [`BCS_IOADDR_MSB-`BCS_IOADDR_LSB:0] chk_iobase;
    logic [`BCS_IOADDR_MSB-`BCS_IOADDR_LSB:0] chk_iolimit;
    assign chk_maddr = I_MEM_ADDR[`BCS_MADDR_MSB:`BCS_MADDR_LSB];
    assign chk_mbase = I_MEM_WIN.base[`BCS_MWIN_MSB:`BCS_MWIN_LSB];
    assign chk_mlimit = I_MEM_WIN.limit[`BCS_MWIN_MSB:`BCS_MWIN_LSB];
    assign chk_ioaddr = I_IO_ADDR[`BCS_IOADDR_MSB:`BCS_IOADDR_LSB];
    assign chk_iobase = I_IO_BASE[`BCS_IOWIN_MSB:`BCS_IOWIN_LSB];
    assign chk_iolimit = I_IO_LIMIT[`BCS_IOWIN_MSB:`BCS_IOWIN_LSB];

    AST_CMD_FIXED_ZERO: assert property (
        O_CFG.rvalid |-> (O_CFG.rdata[15:0] & ~`BCS_CMD_WMASK) == 16'h0000)
        else $error("Command hardwired bits read nonzero.");

    AST_NO_MSG_DISABLED: assert property (
        !cmd_q[`BCS_CMD_SERRE] |-> !O_SYSERR_MSG_VALID)
        else $error("Message raised while enable is clear.");

    AST_MSG_ON_ERROR: assert property (
        (msg_state_q == BCS_MSG_IDLE && err_pending && cmd_q[`BCS_CMD_SERRE]
         && !wr_regs) |=> O_SYSERR_MSG_VALID)
        else $error("Enabled error did not raise a message.");

    AST_BME_STORED: assert property (
        (wr_regs && I_CFG.be[0]) |=> cmd_q[`BCS_CMD_BME] == $past(I_CFG.wdata[2]))
        else $error("Bus master bit did not store the written value.");

    AST_MEM_OFF: assert property (
        !cmd_q[`BCS_CMD_MAE] |=> !O_MEM_HIT)
        else $error("Memory hit with memory decode disabled.");

    AST_IO_OFF: assert property (
        !cmd_q[`BCS_CMD_IOAE] |=> !O_IO_HIT)
        else $error("I/O hit with I/O decode disabled.");

    AST_SSE_ON_SEND: assert property (
        msg_sent |=> sse_q ##1 (sse_q || $past(sse_clear)))
        else $error("Flag not set after a message was sent.");

    AST_SSE_STICKY: assert property (
        (sse_q && !sse_clear) |=> sse_q)
        else $error("Flag dropped without a write of one.");

    AST_SSE_CLEAR: assert property (
        (sse_clear && !msg_sent) |=> !sse_q)
        else $error("Write of one did not clear the flag.");

    AST_STS_FIXED: assert property (
        (I_CFG.rd && hits_regs(I_CFG.addr)) |=>
        (O_CFG.rvalid && (O_CFG.rdata[31:16] & ~(16'h0001 << `BCS_STS_SSE))
         == `BCS_STS_FIXED))
        else $error("Status fixed bits read wrong.");

    AST_READ_LATENCY: assert property (
        I_CFG.rd |=> O_CFG.rvalid ##0 (hits_regs($past(I_CFG.addr))
        || O_CFG.rdata == 32'h0000_0000))
        else $error("Read answer late or unmapped read nonzero.");

    AST_MEM_HIT_ON: assert property (
        (cmd_q[`BCS_CMD_MAE] && chk_mbase <= chk_maddr && chk_maddr <= chk_mlimit)
        |=> O_MEM_HIT)
        else $error("Address inside the memory window did not hit.");

    AST_IO_HIT_ON: assert property (
        (cmd_q[`BCS_CMD_IOAE] && chk_iobase <= chk_ioaddr && chk_ioaddr <= chk_iolimit)
        |=> O_IO_HIT)
        else $error("Address inside the I/O window did not hit.");

    AST_MSG_HOLDS: assert property (
        (O_SYSERR_MSG_VALID && !I_SYSERR_MSG_READY && !wr_regs) |=> O_SYSERR_MSG_VALID)
        else $error("Message withdrawn before the hub took it.");

    AST_SSE_ONLY_ON_SEND: assert property (
        (!sse_q && !msg_sent) |=> !sse_q)
        else $error("Flag set without a message being sent.");

    COV_MSG_SENT: cover property (msg_sent ##[1:4] sse_clear);
    COV_SET_AND_CLEAR: cover property (msg_sent && sse_clear);
    COV_MEM_HIT: cover property (O_MEM_HIT);
    COV_IO_HIT: cover property (O_IO_HIT);

endmodule

`default_nettype wire

// *** rtl/bcs_map.svh ***
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH

// Configuration offsets of the two registers; both share the dword at 04h.
`define BCS_CMD_OFFSET 8'h04
`define BCS_STS_OFFSET 8'h06
`define BCS_DWORD_MASK 8'hFC

// Reset values.
`define BCS_CMD_RESET 16'h0000
`define BCS_STS_RESET 16'h00A0

// Command bits that software may change; every other position reads zero.
`define BCS_CMD_WMASK 16'h0107
`define BCS_CMD_IOAE 0
`define BCS_CMD_MAE 1
`define BCS_CMD_BME 2
`define BCS_CMD_SERRE 8

// Status: fixed capability bits and the one sticky flag.
`define BCS_STS_FIXED 16'h00A0
`define BCS_STS_SSE 14
`define BCS_STS_SSE_BYTE 3
`define BCS_STS_SSE_LANE 6
`define BCS_STS_WORD_LSB 16

// Window register fields and the address bits they are compared with.
`define BCS_MWIN_MSB 15
`define BCS_MWIN_LSB 4
`define BCS_MADDR_MSB 31
`define BCS_MADDR_LSB 20
`define BCS_IOWIN_MSB 7
`define BCS_IOWIN_LSB 4
`define BCS_IOADDR_MSB 15
`define BCS_IOADDR_LSB 12

`endif

// *** rtl/bcs_pkg.sv ***
`default_nettype none

package bcs_pkg;
    // One configuration access, dword aligned with byte enables.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } bcs_cfg_req_t;

    // Read answer, one cycle after the read.
    typedef struct packed {
        logic rvalid;
        logic [31:0] rdata;
    } bcs_cfg_rsp_t;

    // One memory window as base and limit registers hold it.
    typedef struct packed {
        logic [15:0] base;
        logic [15:0] limit;
    } bcs_win_t;

    // Message sender states, one-hot.
    typedef enum logic [1:0] {
        BCS_MSG_IDLE = 2'b01,
        BCS_MSG_SEND = 2'b10
    } bcs_msg_state_t;
endpackage

`default_nettype wire

// *** rtl/bcs_range_check.sv ***
`default_nettype none

// Inclusive range compare on the upper address bits of a decode window.
module bcs_range_check #(
    parameter int W = 12
) (
    input wire logic i_enable,
    input wire logic [W-1:0] i_addr,
    input wire logic [W-1:0] i_base,
    input wire logic [W-1:0] i_limit,
    output logic o_hit
);
    // The enable gates the compare so a stale window never claims a cycle.
    assign o_hit = i_enable && (i_base <= i_addr) && (i_addr <= i_limit);
endmodule

`default_nettype wire

// *** tb/bcs_bridge_regs_tb_top.sv ***
`default_nettype none

module bcs_bridge_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bcs_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    bcs_cfg_req_t cfg = '0;
    bcs_cfg_rsp_t rsp;
    logic [3:0] err_event = 4'h0;
    logic [3:0] err_enable = 4'h0;
    logic msg_valid;
    logic msg_ready = 1'b0;
    bcs_win_t mem_win = '0;
    bcs_win_t pmem_win = '0;
    logic [7:0] io_base = 8'hF0;
    logic [7:0] io_limit = 8'h00;
    logic [31:0] mem_addr = 32'h0;
    logic [15:0] io_addr = 16'h0;
    logic mem_hit;
    logic io_hit;
    logic mem_en;
    logic io_en;
    int fail_count = 0;
    int check_count = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Free-running 250 MHz clock.
    always #2 clk = ~clk;

    bcs_bridge_regs #(.NUM_ERR(4)) bcs_bridge_regs_i (
        .I_CLOCK(clk), .I_RST(rst), .I_CFG(cfg), .O_CFG(rsp),
        .I_ERR_EVENT(err_event), .I_ERR_ENABLE(err_enable),
        .O_SYSERR_MSG_VALID(msg_valid), .I_SYSERR_MSG_READY(msg_ready),
        .I_MEM_WIN(mem_win), .I_PMEM_WIN(pmem_win),
        .I_IO_BASE(io_base), .I_IO_LIMIT(io_limit),
        .I_MEM_ADDR(mem_addr), .I_IO_ADDR(io_addr),
        .O_MEM_HIT(mem_hit), .O_IO_HIT(io_hit),
        .O_MEM_ENABLE(mem_en), .O_IO_ENABLE(io_en)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Compare with case inequality so that an unknown never passes.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    // Single exit point for the run.
    task automatic conclude();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Write strobe held over one rising edge; a spare cycle keeps drivers apart.
    task automatic cfg_write(input logic [7:0] addr, input logic [3:0] be,
                             input logic [31:0] data);
        cfg.wr = 1'b1;
        cfg.addr = addr;
        cfg.be = be;
        cfg.wdata = data;
        @(negedge clk);
        cfg.wr = 1'b0;
        @(negedge clk);
    endtask

    // The answer pulse stands one cycle, so it is looked for at each falling edge.
    task automatic cfg_read(input logic [7:0] addr, input logic [31:0] exp);
        int n;
        cfg.rd = 1'b1;
        cfg.addr = addr;
        cfg.be = 4'hF;
        @(negedge clk);
        cfg.rd = 1'b0;
        n = 0;
        while (rsp.rvalid !== 1'b1 && n < 4)
        begin
            @(negedge clk);
            n++;
        end
        if (rsp.rvalid !== 1'b1)
        begin
            fail_count++;
            conclude();
        end
        else
        begin
            check(rsp.rdata, exp);
            @(negedge clk);
        end
    endtask

    // Hits are registered, so they are checked one cycle after the address.
    task automatic probe(input logic [31:0] ma, input logic [15:0] ia,
                         input logic em, input logic ei);
        mem_addr = ma;
        io_addr = ia;
        @(negedge clk);
        check({30'h0, mem_hit, io_hit}, {30'h0, em, ei});
    endtask

    // A few idle cycles in which no message may be offered.
    task automatic quiet_link();
        repeat (4)
        begin
            @(negedge clk);
            check({31'h0, msg_valid}, 32'h0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog so a stuck design cannot hang the run.
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        conclude();
    end

    // Main sequence; every input is changed at the falling edge.
    initial
    begin
        int n;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        cfg_read(8'h04, 32'h00A0_0000);
        check({30'h0, mem_en, io_en}, 32'h0);
        cfg_write(8'h04, 4'hF, 32'hFFFF_FFFF);
        cfg_read(8'h04, 32'h00A0_0107);
        cfg_read(8'h06, 32'h00A0_0107);
        check({30'h0, mem_en, io_en}, 32'h3);
        cfg_write(8'h08, 4'hF, 32'h0000_0000);
        cfg_read(8'h08, 32'h0000_0000);
        cfg_read(8'h04, 32'h00A0_0107);
        // Decode windows: memory 100h..10Fh, prefetch 200h, I/O 2h..3h.
        mem_win.base = 16'h1000;
        mem_win.limit = 16'h10F0;
        pmem_win.base = 16'h2000;
        pmem_win.limit = 16'h2000;
        io_base = 8'h20;
        io_limit = 8'h30;
        // Both command lanes are written so the message enable is cleared too.
        cfg_write(8'h04, 4'h3, 32'h0000_0004);
        cfg_read(8'h04, 32'h00A0_0004);
        probe(32'h1000_0000, 16'h2000, 1'b0, 1'b0);
        cfg_write(8'h04, 4'h1, 32'h0000_0003);
        probe(32'h1000_0000, 16'h2000, 1'b1, 1'b1);
        probe(32'h10FF_FFFF, 16'h3FFF, 1'b1, 1'b1);
        probe(32'h2000_0000, 16'h1FFF, 1'b1, 1'b0);
        probe(32'h1100_0000, 16'h4000, 1'b0, 1'b0);
        cfg_write(8'h04, 4'h1, 32'h0000_0001);
        probe(32'h1000_0000, 16'h2000, 1'b0, 1'b1);
        // Enabled error with messaging off must stay silent.
        err_enable = 4'h2;
        err_event = 4'h2;
        quiet_link();
        cfg_read(8'h04, 32'h00A0_0001);
        cfg_write(8'h04, 4'h2, 32'h0000_0100);
        n = 0;
        while (msg_valid !== 1'b1 && n < 8)
        begin
            @(negedge clk);
            n++;
        end
        check({31'h0, msg_valid}, 32'h1);
        @(negedge clk);
        check({31'h0, msg_valid}, 32'h1);
        // Clear the cause before the hand-off so no second message follows.
        msg_ready = 1'b1;
        err_event = 4'h0;
        @(negedge clk);
        msg_ready = 1'b0;
        check({31'h0, msg_valid}, 32'h0);
        cfg_read(8'h04, 32'h40A0_0101);
        cfg_write(8'h04, 4'hC, 32'hBFFF_0000);
        cfg_read(8'h04, 32'h40A0_0101);
        cfg_write(8'h04, 4'h8, 32'h4000_0000);
        cfg_read(8'h04, 32'h00A0_0101);
        // Message and clearing write in one cycle: the set must win.
        err_event = 4'h2;
        repeat (2) @(negedge clk);
        check({31'h0, msg_valid}, 32'h1);
        msg_ready = 1'b1;
        err_event = 4'h0;
        cfg_write(8'h04, 4'h8, 32'h4000_0000);
        msg_ready = 1'b0;
        cfg_read(8'h04, 32'h40A0_0101);
        cfg_write(8'h04, 4'h8, 32'h4000_0000);
        // An error whose own enable is clear sends nothing.
        err_enable = 4'h1;
        err_event = 4'h2;
        quiet_link();
        cfg_read(8'h04, 32'h00A0_0101);
        // A second reset in mid-run returns both registers to their defaults.
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        cfg_read(8'h04, 32'h00A0_0000);
        check({30'h0, mem_en, io_en}, 32'h0);
        conclude();
    end
endmodule

`default_nettype wire
